// *** rtl/power_event_cause_recorder.v ***
// The plain strobed port was decided locally.
`timescale 1ns/1ns
`include "power_event_cause_regs.vh"

// What this block does
// [R1] Turn-on bit 10 set when last wake came from low-system supply threshold.
// [R2] Low-system threshold never recorded as a full turn-on cause.
// [R3] Turn-on bit 7 set when watchdog caused last wake, else cleared.
// [R4] Turn-on bit 6 set when last wake came from software clearing sleep bit.
// [R5] Turn-on bit 5 set when alarm caused last turn-on or wake.
// [R6] Turn-on bit 4 set when power button caused last turn-on or wake.
// [R7] Turn-on bit 3 set when last turn-on followed converter undervoltage reset.
// [R8] Turn-on bit 2 set when last turn-on followed a software reset.
// [R9] Turn-on bit 1 set when last turn-on followed a hardware reset.
// [R10] Turn-on bit 0 set when last turn-on followed a watchdog reset.
// [R11] All cause flags reset to 0, changed only by the state machine.
// [R12] Each register holds only the latest event, replacing the older record.
// [R13] Turn-off bit 13 set when internal regulator error caused last turn-off.
// [R14] Turn-off bit 12 set when power-up sequence failure caused last turn-off.
// [R15] Turn-off bit 11 set when a GPIO input caused last turn-off.
// [R16] Turn-off bit 10 set when supply low or shutdown threshold caused turn-off.
// [R17] Turn-off bit 9 set when over-temperature caused last turn-off.
// [R18] Turn-off bit 6 set when software cleared the chip-on bit.
// [R19] Turn-off bit 4 set when power button caused last turn-off.
// [R20] Turn-on bit 15 is 1 for full turn-on, 0 for wake.
// [R21] Turn-on bit 11 set when a GPIO input caused last turn-on or wake.
// [R22] Cause registers read-only, reads side-effect free, undefined bits read 0.
module power_event_cause_recorder (
  input  wire        mclk,
  input  wire        reset,
  input  wire        ce,
  input  wire [15:0] addr,
  input  wire [15:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [15:0] rdata_q,
  input  wire        on_event,
  input  wire        full_turn_on_flag,
  input  wire        up_by_gpio,
  input  wire        wake_by_low_supply,
  input  wire        wake_by_watchdog,
  input  wire        wake_by_software,
  input  wire        up_by_alarm,
  input  wire        up_by_button,
  input  wire        rst_by_converter_undervolt,
  input  wire        rst_by_software,
  input  wire        rst_by_hardware,
  input  wire        rst_by_watchdog,
  input  wire        off_event,
  input  wire        down_by_internal_regulator_error,
  input  wire        down_by_sequence_failure,
  input  wire        down_by_gpio,
  input  wire        down_by_supply_threshold,
  input  wire        down_by_overtemperature,
  input  wire        down_by_software,
  input  wire        down_by_button,
  output wire [15:0] up_cause_q,
  output wire [15:0] down_cause_q,
  output reg         sleep_request_bit_q,
  output reg         chip_on_bit_q,
  output reg         wake_request_q,
  output reg         off_request_q
);

  // Address compare shared by read and write paths
  function hit;
    input [15:0] a;
    input [15:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // True when a cause word names exactly one source
  function single_cause;
    input [15:0] w;
    integer k;
    reg [4:0] n;
    begin
      n = 5'h00;
      for (k = 0; k < 16; k = k + 1) begin
        n = n + {4'h0, w[k]};
      end
      single_cause = (n == 5'h01);
    end
  endfunction

  // Saturating event count; an event in the clear cycle still counts
  function [6:0] count_next;
    input [6:0] cnt;
    input       inc;
    input       clr;
    reg   [6:0] base;
    begin
      base = clr ? 7'h00 : cnt;
      if (inc && (base != `COUNT_MAX)) begin
        count_next = base + 7'h01;
      end else begin
        count_next = base;
      end
    end
  endfunction

  reg  [15:0] up_raw;
  reg  [15:0] up_word;
  reg  [15:0] down_word;
  reg  [15:0] rdata_d;
  reg         sleep_d;
  reg         chip_on_d;
  reg         wake_req_d;
  reg         off_req_d;
  reg  [6:0]  on_cnt_q;
  reg  [6:0]  off_cnt_q;
  reg         last_off_q;
  reg         ambiguous_q;
  reg         ambiguous_d;
  wire        ctrl_wr;
  wire        count_clear;
  wire        sel_up;
  wire        sel_down;
  wire        sel_ctrl;
  wire        sel_stat;
  wire [3:0]  rsel;
  reg  [15:0] ctrl_word;
  reg  [15:0] status_word;

  // One-hot register select codes for the read mux
  localparam [3:0] RSEL_UP   = 4'h1;
  localparam [3:0] RSEL_DOWN = 4'h2;
  localparam [3:0] RSEL_CTRL = 4'h4;
  localparam [3:0] RSEL_STAT = 4'h8;

  // Address decode shared by read and write paths
  assign sel_up   = hit(addr, `OFS_POWER_UP_CAUSE);
  assign sel_down = hit(addr, `OFS_POWER_DOWN_CAUSE);
  assign sel_ctrl = hit(addr, `OFS_CAUSE_CTRL);
  assign sel_stat = hit(addr, `OFS_EVENT_STATUS);
  assign rsel     = {sel_stat, sel_ctrl, sel_down, sel_up};

  // Gather turn-on causes into register layout
  always @* begin
    up_raw = 16'h0000;
    up_raw[`UP_FULL_BIT]       = full_turn_on_flag; // R20
    up_raw[`UP_GPIO_BIT]       = up_by_gpio; // R21
    up_raw[`UP_LOW_SUPPLY_BIT] = wake_by_low_supply; // R1
    up_raw[`UP_WATCHDOG_BIT]   = wake_by_watchdog; // R3
    up_raw[`UP_SOFTWARE_BIT]   = wake_by_software; // R4
    up_raw[`UP_ALARM_BIT]      = up_by_alarm; // R5
    up_raw[`UP_BUTTON_BIT]     = up_by_button; // R6
    up_raw[`RST_CNV_UV_BIT]    = rst_by_converter_undervolt; // R7
    up_raw[`RST_SOFTWARE_BIT]  = rst_by_software; // R8
    up_raw[`RST_HARDWARE_BIT]  = rst_by_hardware; // R9
    up_raw[`RST_WATCHDOG_BIT]  = rst_by_watchdog; // R10
  end

  // Wake-only causes drop out on full turn-on, reset causes on wake
  always @* begin
    if (full_turn_on_flag) begin
      up_word = up_raw & ~`UP_WAKE_ONLY_MASK; // R2
    end else begin
      up_word = up_raw & ~`UP_FULL_ONLY_MASK;
    end
  end

  // Gather turn-off causes into register layout
  always @* begin
    down_word = 16'h0000;
    down_word[`DOWN_REG_ERR_BIT]  = down_by_internal_regulator_error; // R13
    down_word[`DOWN_SEQ_FAIL_BIT] = down_by_sequence_failure; // R14
    down_word[`DOWN_GPIO_BIT]     = down_by_gpio; // R15
    down_word[`DOWN_SUPPLY_BIT]   = down_by_supply_threshold; // R16
    down_word[`DOWN_OVERTEMP_BIT] = down_by_overtemperature; // R17
    down_word[`DOWN_SOFTWARE_BIT] = down_by_software; // R18
    down_word[`DOWN_BUTTON_BIT]   = down_by_button; // R19
  end

  // Cause registers load only on state machine events
  cause_latch u_up_cause (
    .mclk       (mclk),
    .reset      (reset),
    .ce         (ce),
    .load       (on_event), // R11 R12
    .cause_in   (up_word),
    .valid_mask (`UP_VALID_MASK), // R22
    .word_q     (up_cause_q)
  );

  cause_latch u_down_cause (
    .mclk       (mclk),
    .reset      (reset),
    .ce         (ce),
    .load       (off_event), // R11 R12
    .cause_in   (down_word),
    .valid_mask (`DOWN_VALID_MASK), // R22
    .word_q     (down_cause_q)
  );

  // Control register writes
  assign ctrl_wr     = wr && sel_ctrl;
  assign count_clear = ctrl_wr && wdata[`CTRL_COUNT_CLEAR_BIT];

  always @* begin
    sleep_d    = sleep_request_bit_q;
    chip_on_d  = chip_on_bit_q;
    wake_req_d = 1'b0;
    off_req_d  = 1'b0;
    if (ctrl_wr) begin
      sleep_d   = wdata[`CTRL_SLEEP_BIT];
      chip_on_d = wdata[`CTRL_CHIP_ON_BIT];
      // Clearing the sleep bit asks the state machine for a wake
      wake_req_d = sleep_request_bit_q && !wdata[`CTRL_SLEEP_BIT];
      // Clearing the chip-on bit asks the state machine to turn off
      off_req_d  = chip_on_bit_q && !wdata[`CTRL_CHIP_ON_BIT];
    end
  end

  always @(posedge mclk) begin
    if (reset) begin
      sleep_request_bit_q <= `SLEEP_RESET;
      chip_on_bit_q       <= `CHIP_ON_RESET;
      wake_request_q      <= 1'b0;
      off_request_q       <= 1'b0;
    end else if (ce) begin
      sleep_request_bit_q <= sleep_d;
      chip_on_bit_q       <= chip_on_d;
      wake_request_q      <= wake_req_d;
      off_request_q       <= off_req_d;
    end
  end

  // Event bookkeeping; turn-off wins when both events coincide
  always @* begin
    ambiguous_d = ambiguous_q;
    if (off_event) begin
      ambiguous_d = !single_cause(down_word);
    end else if (on_event) begin
      ambiguous_d = !single_cause(up_word & ~(16'h0001 << `UP_FULL_BIT));
    end
  end

  always @(posedge mclk) begin
    if (reset) begin
      on_cnt_q    <= 7'h00;
      off_cnt_q   <= 7'h00;
      last_off_q  <= 1'b0;
      ambiguous_q <= 1'b0;
    end else if (ce) begin
      on_cnt_q    <= count_next(on_cnt_q, on_event, count_clear);
      off_cnt_q   <= count_next(off_cnt_q, off_event, count_clear);
      ambiguous_q <= ambiguous_d;
      if (off_event) begin
        last_off_q <= 1'b1;
      end else if (on_event) begin
        last_off_q <= 1'b0;
      end
    end
  end

  // Control word; the count clear bit is a strobe and reads 0
  always @* begin
    ctrl_word                    = 16'h0000;
    ctrl_word[`CTRL_SLEEP_BIT]   = sleep_request_bit_q;
    ctrl_word[`CTRL_CHIP_ON_BIT] = chip_on_bit_q;
  end

  // Status word built from its field positions
  always @* begin
    status_word                         = 16'h0000;
    status_word[`STAT_LAST_OFF_BIT]     = last_off_q;
    status_word[`STAT_OFF_CNT_LSB +: 7] = off_cnt_q;
    status_word[`STAT_AMBIGUOUS_BIT]    = ambiguous_q;
    status_word[`STAT_ON_CNT_LSB +: 7]  = on_cnt_q;
  end

  // Read mux; nothing here alters stored state
  always @* begin
    rdata_d = 16'h0000;
    if (rd) begin
      case (rsel)
        RSEL_UP: begin
          rdata_d = up_cause_q; // R22
        end
        RSEL_DOWN: begin
          rdata_d = down_cause_q; // R22
        end
        RSEL_CTRL: begin
          rdata_d = ctrl_word;
        end
        RSEL_STAT: begin
          rdata_d = status_word;
        end
        default: begin
          rdata_d = 16'h0000;
        end
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge mclk) begin
    if (reset) begin
      rdata_q <= 16'h0000;
    end else if (ce) begin
      rdata_q <= rdata_d;
    end
  end

endmodule // power_event_cause_recorder

// *** common/power_event_cause_regs.vh ***
`ifndef POWER_EVENT_CAUSE_REGS_VH
`define POWER_EVENT_CAUSE_REGS_VH

// Register offsets
`define OFS_POWER_UP_CAUSE    16'h400e
`define OFS_POWER_DOWN_CAUSE  16'h400f
`define OFS_CAUSE_CTRL        16'h4100
`define OFS_EVENT_STATUS      16'h4101

// Turn-on cause bit positions
`define UP_FULL_BIT           15
`define UP_GPIO_BIT           11
`define UP_LOW_SUPPLY_BIT     10
`define UP_WATCHDOG_BIT       7
`define UP_SOFTWARE_BIT       6
`define UP_ALARM_BIT          5
`define UP_BUTTON_BIT         4
`define RST_CNV_UV_BIT        3
`define RST_SOFTWARE_BIT      2
`define RST_HARDWARE_BIT      1
`define RST_WATCHDOG_BIT      0

// Turn-off cause bit positions
`define DOWN_REG_ERR_BIT      13
`define DOWN_SEQ_FAIL_BIT     12
`define DOWN_GPIO_BIT         11
`define DOWN_SUPPLY_BIT       10
`define DOWN_OVERTEMP_BIT     9
`define DOWN_SOFTWARE_BIT     6
`define DOWN_BUTTON_BIT       4

// Defined bit masks
`define UP_VALID_MASK         16'h8cff
`define DOWN_VALID_MASK       16'h3e50
`define UP_WAKE_ONLY_MASK     16'h04c0
`define UP_FULL_ONLY_MASK     16'h000f

// Control register fields
`define CTRL_SLEEP_BIT        0
`define CTRL_CHIP_ON_BIT      1
`define CTRL_COUNT_CLEAR_BIT  2
`define CTRL_READ_MASK        16'h0003

// Event status fields
`define STAT_LAST_OFF_BIT     15
`define STAT_OFF_CNT_LSB      8
`define STAT_AMBIGUOUS_BIT    7
`define STAT_ON_CNT_LSB       0
`define COUNT_MAX             7'h7f

// Reset values
`define CAUSE_RESET           16'h0000
`define SLEEP_RESET           1'h0
`define CHIP_ON_RESET         1'h1

`endif

// *** rtl/cause_latch.v ***
`timescale 1ns/1ns

// Holds one cause word; a load replaces every defined bit at once.
module cause_latch (
  input  wire        mclk,
  input  wire        reset,
  input  wire        ce,
  input  wire        load,
  input  wire [15:0] cause_in,
  input  wire [15:0] valid_mask,
  output wire [15:0] word_q
);

  reg [15:0] bits_q;

  genvar i;
  generate
    for (i = 0; i < 16; i = i + 1) begin : g_bit
      always @(posedge mclk) begin
        if (reset) begin
          bits_q[i] <= 1'b0; // R11
        end else if (ce && load) begin
          bits_q[i] <= cause_in[i] & valid_mask[i]; // R12 R22
        end
      end
    end
  endgenerate

  assign word_q = bits_q;

endmodule // cause_latch

// *** dv/cause_chk.sv ***
`timescale 1ns/1ns
module cause_chk (
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        ce,
  input wire logic [15:0] addr,
  input wire logic        rd,
  input wire logic [15:0] rdata_q,
  input wire logic        on_event,
  input wire logic        full_turn_on_flag,
  input wire logic        wake_by_low_supply,
  input wire logic        off_event,
  input wire logic        down_by_button,
  input wire logic [15:0] up_cause_q,
  input wire logic [15:0] down_cause_q
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  wire up_go = on_event && ce;
  wire dn_go = off_event && ce;
  AST_UP_LOW: assert property (
    up_go && !full_turn_on_flag |=> up_cause_q[10] == $past(wake_by_low_supply))
    else $error("low supply wake flag wrong");
  AST_FULL_NO_WAKE: assert property (
    up_go && full_turn_on_flag |=> (up_cause_q & 16'h04c0) == 16'h0000)
    else $error("wake cause on full turn-on");
  AST_WAKE_NO_RST: assert property (
    up_go && !full_turn_on_flag |=> up_cause_q[3:0] == 4'h0)
    else $error("reset cause on wake");
  AST_FULL_FLAG: assert property (
    up_go |=> up_cause_q[15] == $past(full_turn_on_flag))
    else $error("full turn-on flag wrong");
  AST_UP_HOLD: assert property (
    !up_go |=> $stable(up_cause_q))
    else $error("turn-on word changed without event");
  AST_DN_HOLD: assert property (
    !dn_go |=> $stable(down_cause_q))
    else $error("turn-off word changed without event");
  AST_UNDEF: assert property (
    (up_cause_q & 16'h7300) == 16'h0000 && (down_cause_q & 16'hc1af) == 16'h0000)
    else $error("undefined cause bit set");
  AST_DN_BUTTON: assert property (
    dn_go |=> down_cause_q[4] == $past(down_by_button))
    else $error("button turn-off flag wrong");
  AST_READ_UP: assert property (
    rd && ce && addr == 16'h400e && !on_event |=> rdata_q == up_cause_q)
    else $error("turn-on read data wrong");
  AST_RDATA_IDLE: assert property (
    ce && !rd |=> rdata_q == 16'h0000)
    else $error("read data outside read cycle");
  C_WAKE: cover property (up_go && !full_turn_on_flag);
  C_FULL: cover property (up_go && full_turn_on_flag);
  C_OFF: cover property (dn_go);
endmodule // cause_chk

bind power_event_cause_recorder cause_chk i_chk (
  .mclk(mclk), .reset(reset), .ce(ce), .addr(addr), .rd(rd), .rdata_q(rdata_q),
  .on_event(on_event), .full_turn_on_flag(full_turn_on_flag),
  .wake_by_low_supply(wake_by_low_supply), .off_event(off_event),
  .down_by_button(down_by_button), .up_cause_q(up_cause_q), .down_cause_q(down_cause_q)
);

// *** dv/test_power_event_cause_recorder.sv ***
`timescale 1ns/1ns
`include "power_event_cause_regs.vh"
module test_power_event_cause_recorder;
  logic        mclk = 1'h0;
  logic        reset = 1'h1;
  logic [15:0] addr = 16'h0000;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'h0;
  logic        rd = 1'h0;
  logic        ce = 1'h1;
  logic        on_ev = 1'h0;
  logic        off_ev = 1'h0;
  logic        full = 1'h0;
  logic [9:0]  upc = 10'h000;
  logic [6:0]  dnc = 7'h00;
  wire  [15:0] rdata_q;
  wire  [15:0] up_q;
  wire  [15:0] dn_q;
  wire         slp_q;
  wire         chip_q;
  wire         wake_q;
  wire         off_q;
  int          num_errors = 0;
  int          n_tests = 0;
  int          up_exp = 0;
  int          dn_exp = 0;
  int          sel;
  int          sleep_m = 0;
  int          chip_m = 1;
  int          last_off = 0;
  int          amb = 0;
  int          hist_q[$];
  always #5 mclk = ~mclk;
  power_event_cause_recorder i_dut (
    .mclk(mclk), .reset(reset), .ce(ce), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata_q(rdata_q), .on_event(on_ev), .full_turn_on_flag(full),
    .up_by_gpio(upc[9]), .wake_by_low_supply(upc[8]), .wake_by_watchdog(upc[7]),
    .wake_by_software(upc[6]), .up_by_alarm(upc[5]), .up_by_button(upc[4]),
    .rst_by_converter_undervolt(upc[3]), .rst_by_software(upc[2]),
    .rst_by_hardware(upc[1]), .rst_by_watchdog(upc[0]), .off_event(off_ev),
    .down_by_internal_regulator_error(dnc[6]), .down_by_sequence_failure(dnc[5]),
    .down_by_gpio(dnc[4]), .down_by_supply_threshold(dnc[3]),
    .down_by_overtemperature(dnc[2]), .down_by_software(dnc[1]), .down_by_button(dnc[0]),
    .up_cause_q(up_q), .down_cause_q(dn_q), .sleep_request_bit_q(slp_q),
    .chip_on_bit_q(chip_q), .wake_request_q(wake_q), .off_request_q(off_q)
  );
  task automatic chk(string nm, int exp, logic [15:0] got);
    n_tests++;
    if (got !== exp[15:0]) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp[15:0], got);
    end
  endtask
  task automatic rd_chk(logic [15:0] a, int exp);
    @(posedge mclk);
    rd <= 1'h1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'h0;
    #1;
    chk("rdata_q", exp, rdata_q);
    @(posedge mclk);
    #1;
    chk("rdata_q idle", 0, rdata_q);
  endtask
  task automatic wr_reg(logic [15:0] a, logic [15:0] d);
    @(posedge mclk);
    wr <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'h0;
  endtask
  // Control write with random bits; the count clear is rare so counts build up
  task automatic ctrl_wr();
    logic [15:0] d;
    d = $urandom;
    d[2] = ($urandom_range(7) == 0);
    wr_reg(`OFS_CAUSE_CTRL, d);
    #1;
    chk("wake_request_q", sleep_m && !d[0], wake_q);
    chk("off_request_q", chip_m && !d[1], off_q);
    sleep_m = d[0];
    chip_m = d[1];
    if (d[2]) hist_q.delete();
    chk("sleep_request_bit_q", sleep_m, slp_q);
    chk("chip_on_bit_q", chip_m, chip_q);
    @(posedge mclk);
    #1;
    chk("wake_request_q", 0, wake_q);
    chk("off_request_q", 0, off_q);
  endtask
  // Expected status word from the event history since the last count clear
  function automatic int stat_exp();
    int on_n = 0;
    int off_n = 0;
    foreach (hist_q[k]) begin
      on_n += hist_q[k] & 1;
      off_n += hist_q[k] >> 1;
    end
    if (on_n > 127) on_n = 127;
    if (off_n > 127) off_n = 127;
    return (last_off << 15) | (off_n << 8) | (amb << 7) | on_n;
  endfunction
  // One event cycle, then noise on the cause lines; en low freezes the block
  task automatic fire(int s, bit en);
    bit       f;
    bit [9:0] cu;
    bit [6:0] cd;
    int       w;
    f = $urandom_range(1);
    cu = $urandom;
    cd = $urandom;
    @(posedge mclk);
    ce <= en;
    on_ev <= s[0];
    off_ev <= s[1];
    full <= f;
    upc <= cu;
    dnc <= cd;
    w = {f, 3'h0, cu[9:8], 2'h0, cu[7:0]};
    if (en && s[0]) up_exp = f ? (w & ~`UP_WAKE_ONLY_MASK) : (w & ~`UP_FULL_ONLY_MASK);
    if (en && s[1]) dn_exp = {2'h0, cd[6:2], 2'h0, cd[1], 1'h0, cd[0], 4'h0};
    if (en && s != 0) begin
      hist_q.push_back(s);
      last_off = s[1];
      amb = s[1] ? ($countones(dn_exp) != 1) : ($countones(up_exp & 16'h7fff) != 1);
    end
    @(posedge mclk);
    ce <= 1'h1;
    on_ev <= 1'h0;
    off_ev <= 1'h0;
    full <= ~f;
    upc <= ~cu;
    dnc <= ~cd;
    #1;
    chk("up_cause_q", up_exp, up_q);
    chk("down_cause_q", dn_exp, dn_q);
  endtask
  task automatic report_and_stop;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge mclk);
    num_errors++;
    report_and_stop;
  end
  initial begin
    sel = $urandom(91614);
    repeat (20) @(posedge mclk);
    reset <= 1'h0;
    rd_chk(`OFS_POWER_UP_CAUSE, 0);
    rd_chk(`OFS_POWER_DOWN_CAUSE, 0);
    chk("chip_on_bit_q", 1, chip_q);
    chk("sleep_request_bit_q", 0, slp_q);
    repeat (80) begin
      fire($urandom_range(3), $urandom_range(3) != 0);
      sel = $urandom_range(1);
      wr_reg(sel ? `OFS_POWER_UP_CAUSE : `OFS_POWER_DOWN_CAUSE, $urandom);
      rd_chk(`OFS_POWER_UP_CAUSE, up_exp);
      rd_chk(`OFS_POWER_DOWN_CAUSE, dn_exp);
      rd_chk(`OFS_EVENT_STATUS, stat_exp());
      ctrl_wr();
      rd_chk(`OFS_CAUSE_CTRL, chip_m * 2 + sleep_m);
    end
    rd_chk(16'h4003, 0);
    @(posedge mclk);
    reset <= 1'h1;
    @(posedge mclk);
    reset <= 1'h0;
    up_exp = 0;
    dn_exp = 0;
    hist_q.delete();
    last_off = 0;
    amb = 0;
    sleep_m = 0;
    chip_m = 1;
    rd_chk(`OFS_POWER_UP_CAUSE, 0);
    rd_chk(`OFS_POWER_DOWN_CAUSE, 0);
    rd_chk(`OFS_EVENT_STATUS, stat_exp());
    rd_chk(`OFS_CAUSE_CTRL, chip_m * 2 + sleep_m);
    chk("chip_on_bit_q", chip_m, chip_q);
    chk("sleep_request_bit_q", sleep_m, slp_q);
    report_and_stop;
  end
endmodule // test_power_event_cause_recorder
